// file: hw/bsfx_pkg.sv
// Purpose: Shared constants, operation codes and carrier structs for the
//          branch, skip, compare and fractional multiply execution block.
// Assumes: One core clock, synchronous active-high reset, 16-bit word PC.
// Notes:   Status bit positions and register offsets are fixed here only.

package bsfx_pkg;

   // ********************************************************************
   // Widths, flag positions and masks
   // ********************************************************************
   localparam int unsigned BSFX_PC_W = 16;
   localparam int unsigned BSFX_REG_AW = 4;

   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;

   localparam logic [7:0] MASK_MUL = 8'h03;
   localparam logic [7:0] MASK_CMP = 8'h2F;
   localparam logic [7:0] MASK_NONE = 8'h00;

   // ********************************************************************
   // Cycle counts and program counter steps
   // ********************************************************************
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   localparam logic [15:0] PC_STEP = 16'h0001;
   localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
   localparam logic [15:0] PC_SKIP_TWO = 16'h0003;

   // ********************************************************************
   // Register port map and reset values
   // ********************************************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h1;
   localparam logic [3:0] ADDR_TAKEN = 4'h2;
   localparam logic [3:0] ADDR_PC_LO = 4'h3;
   localparam logic [3:0] ADDR_PC_HI = 4'h4;

   localparam logic [7:0] CTRL_RESET = 8'h01;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_TAKEN_BIT = 1;
   localparam int unsigned STAT_CYC_LSB = 2;

   // ********************************************************************
   // Operations and carriers
   // ********************************************************************
   typedef enum logic [5:0] {
      op_nop,
      op_mul_signed_by_unsigned,
      op_frac_mul_unsigned,
      op_frac_mul_signed,
      op_frac_mul_mixed,
      op_indirect_jump,
      op_indirect_call,
      op_compare_skip_equal,
      op_compare_registers,
      op_compare_with_carry,
      op_compare_immediate,
      op_skip_reg_bit_clear,
      op_skip_reg_bit_set,
      op_skip_io_bit_clear,
      op_skip_io_bit_set,
      op_branch_flag_set,
      op_branch_flag_clear,
      op_branch_equal,
      op_branch_not_equal,
      op_branch_carry_set,
      op_branch_carry_clear,
      op_branch_same_higher,
      op_branch_lower,
      op_branch_minus,
      op_branch_plus,
      op_branch_signed_ge,
      op_branch_signed_lt,
      op_branch_halfcarry_set,
      op_branch_halfcarry_clear,
      op_branch_tbit_set,
      op_branch_tbit_clear,
      op_branch_overflow_set,
      op_branch_overflow_clear,
      op_branch_int_enabled,
      op_branch_int_disabled
   } bsfx_op_e;

   typedef struct packed {
      bsfx_op_e op;
      logic [7:0] rd;
      logic [7:0] rr;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [2:0] flag_sel;
      logic [6:0] offset;
      logic [15:0] pc;
      logic [15:0] z_ptr;
      logic [7:0] status;
      logic io_bit;
      logic next_two_word;
   } bsfx_req_s;

   typedef struct packed {
      logic [15:0] pc_next;
      logic prod_wr;
      logic [15:0] product;
      logic [7:0] flag_wr;
      logic [7:0] status;
      logic push;
      logic [15:0] ret_addr;
      logic taken;
      logic [1:0] cycles;
   } bsfx_res_s;

endpackage

// file: hw/bsfx_exec.sv
// Purpose: Executes multiply, indirect jump and call, compare, skip and
//          conditional branch operations for the core sequencer.
// Assumes: The decoder hands over one operation with all operands read.
// Notes:   Results are held stable from res_valid until the next accept.

`timescale 1ns/10ps

module bsfx_exec (
   input wire logic clock,
   input wire logic srst,
   input wire bsfx_pkg::bsfx_req_s req,
   input wire logic req_valid,
   output logic req_ready,
   output bsfx_pkg::bsfx_res_s res,
   output logic res_valid,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   import bsfx_pkg::*;

   // ********************************************************************
   // Helper functions
   // ********************************************************************

   // Status after a compare; the carry form keeps Z only if already set,
   // so that multi-byte compares chain correctly.
   function automatic logic [7:0] bsfx_cmp_status(
      input logic [7:0] st,
      input logic [7:0] a,
      input logic [7:0] b,
      input logic with_carry
   );
      logic [7:0] d;
      logic [7:0] s;
      logic cin;
      cin = with_carry & st[FLAG_C];
      d = a - b - {7'h00, cin};
      s = st;
      s[FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
      s[FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
      s[FLAG_N] = d[7];
      s[FLAG_C] = (~a[7] & b[7]) | (b[7] & d[7]) | (d[7] & ~a[7]);
      s[FLAG_Z] = (d == 8'h00) & (~with_carry | st[FLAG_Z]);
      return s;
   endfunction

   function automatic logic bsfx_flag(
      input logic [7:0] st,
      input logic [2:0] idx
   );
      return st[idx];
   endfunction

   // ********************************************************************
   // Declarations
   // ********************************************************************
   typedef enum logic {
      st_idle,
      st_wait
   } bsfx_state_e;

   bsfx_state_e state_r;
   bsfx_state_e state_nxt;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   bsfx_res_s res_r;
   bsfx_res_s res_c;
   logic res_valid_r;
   logic [7:0] ctrl_r;
   logic [7:0] taken_cnt_r;
   logic [7:0] taken_cnt_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   logic accept;
   logic [15:0] pc_inc;
   logic [15:0] pc_rel;
   logic [15:0] pc_skip;
   logic [1:0] skip_cycles;
   logic mul_a_signed;
   logic mul_b_signed;
   logic mul_frac;
   logic [17:0] mul_full;
   logic [15:0] mul_raw;
   logic [15:0] mul_prod;
   logic [7:0] mul_status;
   logic sel_ctrl;
   logic sel_stat;
   logic sel_taken;
   logic sel_pc_lo;
   logic sel_pc_hi;
   logic taken_inc;
   logic taken_clr;
   logic [7:0] stat_word;

   // ********************************************************************
   // Operand paths
   // ********************************************************************
   assign pc_inc = req.pc + PC_STEP;
   assign pc_rel = req.pc + {{9{req.offset[6]}}, req.offset} + PC_STEP;
   assign pc_skip = req.pc + (req.next_two_word ? PC_SKIP_TWO : PC_SKIP_ONE);
   assign skip_cycles = req.next_two_word ? CYC_THREE : CYC_TWO;

   // Only the signed-by-signed fractional form extends the second operand.
   assign mul_a_signed = (req.op == op_mul_signed_by_unsigned) ||
                         (req.op == op_frac_mul_signed) ||
                         (req.op == op_frac_mul_mixed);
   assign mul_b_signed = (req.op == op_frac_mul_signed);
   assign mul_frac = (req.op == op_frac_mul_unsigned) ||
                     (req.op == op_frac_mul_signed) ||
                     (req.op == op_frac_mul_mixed);
   assign mul_full = 18'($signed({mul_a_signed & req.rd[7], req.rd}) *
                         $signed({mul_b_signed & req.rr[7], req.rr}));
   assign mul_raw = mul_full[15:0];
   assign mul_prod = mul_frac ? {mul_raw[14:0], 1'b0} : mul_raw;

   // Carry takes the product's top bit before the fractional shift.
   always_comb
   begin
      mul_status = req.status;
      mul_status[FLAG_C] = mul_raw[15];
      mul_status[FLAG_Z] = (mul_prod == 16'h0000);
   end

   // ********************************************************************
   // Operation decode
   // ********************************************************************
   always_comb
   begin
      logic is_skip;
      logic is_branch;
      logic cond;
      is_skip = req.op inside {op_compare_skip_equal,
                               [op_skip_reg_bit_clear:op_skip_io_bit_set]};
      is_branch = req.op inside {[op_branch_flag_set:op_branch_int_disabled]};
      cond = 1'b0;
      res_c.pc_next = pc_inc;
      res_c.prod_wr = 1'b0;
      res_c.product = mul_prod;
      res_c.flag_wr = MASK_NONE;
      res_c.status = req.status;
      res_c.push = 1'b0;
      res_c.ret_addr = pc_inc;
      res_c.taken = 1'b0;
      res_c.cycles = CYC_ONE;
      unique case (req.op)
         op_mul_signed_by_unsigned:
         begin
            res_c.prod_wr = 1'b1;
            res_c.flag_wr = MASK_MUL;
            res_c.status = mul_status;
            res_c.cycles = CYC_TWO;
         end
         op_frac_mul_unsigned, op_frac_mul_signed, op_frac_mul_mixed:
         begin
            res_c.prod_wr = 1'b1;
            res_c.flag_wr = MASK_MUL;
            res_c.status = mul_status;
            res_c.cycles = CYC_TWO;
         end
         op_indirect_jump:
         begin
            res_c.pc_next = req.z_ptr;
            res_c.taken = 1'b1;
            res_c.cycles = CYC_TWO;
         end
         op_indirect_call:
         begin
            res_c.pc_next = req.z_ptr;
            res_c.push = 1'b1;
            res_c.taken = 1'b1;
            res_c.cycles = CYC_THREE;
         end
         op_compare_skip_equal: cond = (req.rd == req.rr);
         op_compare_registers:
         begin
            res_c.flag_wr = MASK_CMP;
            res_c.status = bsfx_cmp_status(req.status, req.rd, req.rr, 1'b0);
         end
         op_compare_with_carry:
         begin
            res_c.flag_wr = MASK_CMP;
            res_c.status = bsfx_cmp_status(req.status, req.rd, req.rr, 1'b1);
         end
         op_compare_immediate:
         begin
            res_c.flag_wr = MASK_CMP;
            res_c.status = bsfx_cmp_status(req.status, req.rd, req.imm, 1'b0);
         end
         op_skip_reg_bit_clear: cond = ~req.rr[req.bit_sel];
         op_skip_reg_bit_set: cond = req.rr[req.bit_sel];
         op_skip_io_bit_clear: cond = ~req.io_bit;
         op_skip_io_bit_set: cond = req.io_bit;
         op_branch_flag_set: cond = bsfx_flag(req.status, req.flag_sel);
         op_branch_flag_clear: cond = ~bsfx_flag(req.status, req.flag_sel);
         op_branch_equal: cond = bsfx_flag(req.status, FLAG_Z);
         op_branch_not_equal: cond = ~bsfx_flag(req.status, FLAG_Z);
         op_branch_carry_set, op_branch_lower:
            cond = bsfx_flag(req.status, FLAG_C);
         op_branch_carry_clear, op_branch_same_higher:
            cond = ~bsfx_flag(req.status, FLAG_C);
         op_branch_minus: cond = bsfx_flag(req.status, FLAG_N);
         op_branch_plus: cond = ~bsfx_flag(req.status, FLAG_N);
         op_branch_signed_ge: cond = ~(req.status[FLAG_N] ^ req.status[FLAG_V]);
         op_branch_signed_lt: cond = req.status[FLAG_N] ^ req.status[FLAG_V];
         op_branch_halfcarry_set: cond = bsfx_flag(req.status, FLAG_H);
         op_branch_halfcarry_clear: cond = ~bsfx_flag(req.status, FLAG_H);
         op_branch_tbit_set: cond = bsfx_flag(req.status, FLAG_T);
         op_branch_tbit_clear: cond = ~bsfx_flag(req.status, FLAG_T);
         op_branch_overflow_set: cond = bsfx_flag(req.status, FLAG_V);
         op_branch_overflow_clear: cond = ~bsfx_flag(req.status, FLAG_V);
         op_branch_int_enabled: cond = bsfx_flag(req.status, FLAG_I);
         op_branch_int_disabled: cond = ~bsfx_flag(req.status, FLAG_I);
         // No-operation and unused codes take one cycle.
         default: res_c.cycles = CYC_ONE;
      endcase
      if (is_skip && cond)
      begin
         res_c.pc_next = pc_skip;
         res_c.taken = 1'b1;
         res_c.cycles = skip_cycles;
      end
      if (is_branch && cond)
      begin
         res_c.pc_next = pc_rel;
         res_c.taken = 1'b1;
         res_c.cycles = CYC_TWO;
      end
   end

   // ********************************************************************
   // Sequencer
   // ********************************************************************
   // The whole result is computed in the accept cycle and held; later
   // cycles only stretch the operation to its documented length.
   assign req_ready = (state_r == st_idle) && ctrl_r[CTRL_EN_BIT];
   assign accept = req_valid && req_ready;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         st_idle:
         begin
            if (accept && (res_c.cycles != CYC_ONE))
            begin
               state_nxt = st_wait;
               cnt_nxt = res_c.cycles - CYC_TWO;
            end
         end
         st_wait:
         begin
            if (cnt_r == 2'h0)
            begin
               state_nxt = st_idle;
            end
            else
            begin
               cnt_nxt = cnt_r - 2'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_r <= st_idle;
         cnt_r <= 2'h0;
         res_r <= '0;
         res_valid_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         res_valid_r <= (accept && (res_c.cycles == CYC_ONE)) ||
                        ((state_r == st_wait) && (cnt_r == 2'h0));
         if (accept)
         begin
            res_r <= res_c;
         end
      end
   end

   assign res = res_r;
   assign res_valid = res_valid_r;

   // ********************************************************************
   // Register port
   // ********************************************************************
   assign sel_ctrl = (reg_addr == ADDR_CTRL);
   assign sel_stat = (reg_addr == ADDR_STAT);
   assign sel_taken = (reg_addr == ADDR_TAKEN);
   assign sel_pc_lo = (reg_addr == ADDR_PC_LO);
   assign sel_pc_hi = (reg_addr == ADDR_PC_HI);

   // A completion landing on the clearing write still counts.
   assign taken_inc = res_valid_r && res_r.taken;
   assign taken_clr = reg_wr && sel_taken;
   assign taken_cnt_nxt = taken_clr ? {7'h00, taken_inc} :
                          taken_cnt_r + {7'h00, taken_inc};

   always_comb
   begin
      stat_word = 8'h00;
      stat_word[STAT_BUSY_BIT] = (state_r != st_idle);
      stat_word[STAT_TAKEN_BIT] = res_r.taken;
      stat_word[STAT_CYC_LSB +: 2] = res_r.cycles;
   end

   assign rdata_nxt = !reg_rd ? 8'h00 :
                      sel_ctrl ? ctrl_r :
                      sel_stat ? stat_word :
                      sel_taken ? taken_cnt_r :
                      sel_pc_lo ? res_r.pc_next[7:0] :
                      sel_pc_hi ? res_r.pc_next[15:8] :
                      8'h00;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         ctrl_r <= CTRL_RESET;
         taken_cnt_r <= 8'h00;
         rdata_r <= 8'h00;
      end
      else
      begin
         if (reg_wr && sel_ctrl)
         begin
            ctrl_r <= reg_wdata;
         end
         taken_cnt_r <= taken_cnt_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

endmodule

// file: verification/bsfx_exec_sva.sv
// Purpose: Port-level assertions for the execution block.
// Assumes: Operands are captured at the accept edge.
// Notes:   Captured copies let results be tied back to their request.

`timescale 1ns/10ps

module bsfx_chk (
   input wire logic clock,
   input wire logic srst,
   input wire bsfx_pkg::bsfx_req_s req,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire bsfx_pkg::bsfx_res_s res,
   input wire logic res_valid,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   import bsfx_pkg::*;
   logic acc;
   bsfx_op_e op_r;
   logic [7:0] st_r;
   logic [7:0] rd_r;
   logic [7:0] rr_r;
   logic [15:0] pc_r;
   logic [15:0] z_r;
   logic [6:0] off_r;
   logic [2:0] fs_r;
   assign acc = req_valid && req_ready;

   always_ff @(posedge clock)
   begin
      if (srst)
         op_r <= op_nop;
      else if (acc)
         op_r <= req.op;
   end

   // Operand copies need no reset: they are only read after an accept has loaded them.
   always_ff @(posedge clock)
   begin
      if (acc)
      begin
         st_r <= req.status;
         rd_r <= req.rd;
         rr_r <= req.rr;
         pc_r <= req.pc;
         z_r <= req.z_ptr;
         off_r <= req.offset;
         fs_r <= req.flag_sel;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   // ********************************************************************
   // Assertions
   // ********************************************************************
   AST_MUL_TWO: assert property (
      acc && req.op inside {[op_mul_signed_by_unsigned:op_frac_mul_mixed]} |=>
      !res_valid && !req_ready ##1 res_valid && res.cycles == CYC_TWO
      && res.flag_wr == MASK_MUL) else $error("multiply timing or flag mask wrong");
   AST_FRAC_SHIFT: assert property (
      acc && req.op inside {[op_frac_mul_unsigned:op_frac_mul_mixed]} |->
      ##2 res_valid && res.prod_wr && res.product[0] == 1'b0) else $error("product not shifted");
   AST_INDIRECT_JUMP: assert property (
      acc && req.op == op_indirect_jump |-> ##2 res_valid && res.pc_next == z_r
      && res.flag_wr == MASK_NONE) else $error("indirect jump wrong");
   AST_INDIRECT_CALL: assert property (
      acc && req.op == op_indirect_call |=> !res_valid [*2] ##1 res_valid && res.push
      && res.pc_next == z_r && res.ret_addr == pc_r + PC_STEP) else $error("call wrong");
   AST_COMPARE_SKIP_EQUAL: assert property (
      res_valid && op_r == op_compare_skip_equal |-> res.flag_wr == MASK_NONE
      && res.taken == (rd_r == rr_r)) else $error("compare skip wrong");
   AST_CMP_ONE: assert property (
      acc && req.op inside {[op_compare_registers:op_compare_immediate]} |=> res_valid
      && res.cycles == CYC_ONE && res.flag_wr == MASK_CMP && res.status[4] == st_r[4])
      else $error("compare wrong");
   AST_SKIP_STEP: assert property (
      res_valid && op_r inside {op_compare_skip_equal,
      [op_skip_reg_bit_clear:op_skip_io_bit_set]} |-> res.pc_next == pc_r + 16'(res.cycles)
      && res.taken == (res.cycles != CYC_ONE)) else $error("skip step wrong");
   AST_BR_TARGET: assert property (
      res_valid && op_r >= op_branch_flag_set |-> res.flag_wr == MASK_NONE && (res.taken ?
      (res.cycles == CYC_TWO && res.pc_next == pc_r + {{9{off_r[6]}}, off_r} + PC_STEP) :
      (res.cycles == CYC_ONE && res.pc_next == pc_r + PC_STEP))) else $error("branch wrong");
   AST_SIGNED_GE: assert property (
      res_valid && op_r == op_branch_signed_ge |-> res.taken == !(st_r[FLAG_N] ^ st_r[FLAG_V]))
      else $error("signed branch wrong");
   AST_LOWER: assert property (
      res_valid && op_r == op_branch_lower |-> res.taken == st_r[FLAG_C])
      else $error("lower branch wrong");
   AST_INT_OFF: assert property (
      res_valid && op_r == op_branch_int_disabled |-> res.taken == !st_r[FLAG_I])
      else $error("interrupt branch wrong");
   AST_FLAG_CLR: assert property (
      res_valid && op_r == op_branch_flag_clear |-> res.taken == !st_r[fs_r])
      else $error("flag branch wrong");
endmodule

bind bsfx_exec bsfx_chk u_chk (.clock, .srst, .req, .req_valid, .req_ready, .res, .res_valid,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

// file: verification/branch_skip_fracmul_exec_tb_top.sv
// Purpose: Self-checking bench for the execution block.
// Assumes: Enable bit set at reset, register reads answer one cycle later.
// Notes:   Expectations are queued at accept and compared at completion.

`timescale 1ns/10ps

module branch_skip_fracmul_exec_tb_top;
   import bsfx_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   bsfx_req_s req = '0;
   logic req_valid = 1'b0;
   logic req_ready;
   bsfx_res_s res;
   logic res_valid;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic rd_d = 1'b0;
   int err_count = 0;
   int n_tests = 0;
   int n_taken = 0;
   bsfx_res_s eq[$];
   logic [7:0] rq[$];
   bsfx_res_s e;
   bsfx_res_s last;
   bsfx_req_s q;

   always #50 clock = ~clock;

   bsfx_exec dut (.clock(clock), .srst(srst), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .res(res), .res_valid(res_valid), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // ********************************************************************
   // Reference model
   // ********************************************************************
   function automatic logic br_cond(bsfx_req_s p);
      logic [7:0] s;
      s = p.status;
      case (p.op)
         op_branch_flag_set: return s[p.flag_sel];
         op_branch_flag_clear: return !s[p.flag_sel];
         op_branch_equal: return s[1];
         op_branch_not_equal: return !s[1];
         op_branch_carry_set, op_branch_lower: return s[0];
         op_branch_carry_clear, op_branch_same_higher: return !s[0];
         op_branch_minus: return s[2];
         op_branch_plus: return !s[2];
         op_branch_signed_ge: return !(s[2] ^ s[3]);
         op_branch_signed_lt: return s[2] ^ s[3];
         op_branch_halfcarry_set: return s[5];
         op_branch_halfcarry_clear: return !s[5];
         op_branch_tbit_set: return s[6];
         op_branch_tbit_clear: return !s[6];
         op_branch_overflow_set: return s[3];
         op_branch_overflow_clear: return !s[3];
         op_branch_int_enabled: return s[7];
         default: return !s[7];
      endcase
   endfunction

   function automatic bsfx_res_s model(bsfx_req_s p);
      bsfx_res_s r;
      logic [15:0] a;
      logic [15:0] b;
      logic [8:0] d;
      logic [7:0] k;
      logic sk;
      r = '0;
      sk = 1'b0;
      r.status = p.status;
      r.pc_next = p.pc + 16'h0001;
      r.ret_addr = r.pc_next;
      r.cycles = 2'h1;
      case (p.op)
         op_mul_signed_by_unsigned, op_frac_mul_unsigned, op_frac_mul_signed,
         op_frac_mul_mixed:
         begin
            a = (p.op == op_frac_mul_unsigned) ? {8'h00, p.rd} : {{8{p.rd[7]}}, p.rd};
            b = (p.op == op_frac_mul_signed) ? {{8{p.rr[7]}}, p.rr} : {8'h00, p.rr};
            a = a * b;
            r.status[0] = a[15];
            if (p.op != op_mul_signed_by_unsigned)
               a = a << 1;
            r.status[1] = (a == 16'h0000);
            r.product = a;
            r.prod_wr = 1'b1;
            r.flag_wr = 8'h03;
            r.cycles = 2'h2;
         end
         op_indirect_jump, op_indirect_call:
         begin
            r.pc_next = p.z_ptr;
            r.taken = 1'b1;
            r.push = (p.op == op_indirect_call);
            r.cycles = r.push ? 2'h3 : 2'h2;
         end
         op_compare_registers, op_compare_with_carry, op_compare_immediate:
         begin
            k = (p.op == op_compare_immediate) ? p.imm : p.rr;
            d = {1'b0, p.rd} - {1'b0, k} - ((p.op == op_compare_with_carry) ? p.status[0] : 1'b0);
            r.status[0] = d[8];
            r.status[1] = (d[7:0] == 8'h00) && (p.op != op_compare_with_carry || p.status[1]);
            r.status[2] = d[7];
            r.status[3] = (p.rd[7] & ~k[7] & ~d[7]) | (~p.rd[7] & k[7] & d[7]);
            r.status[5] = (~p.rd[3] & k[3]) | (k[3] & d[3]) | (d[3] & ~p.rd[3]);
            r.flag_wr = 8'h2F;
         end
         op_compare_skip_equal: sk = (p.rd == p.rr);
         op_skip_reg_bit_clear: sk = !p.rr[p.bit_sel];
         op_skip_reg_bit_set: sk = p.rr[p.bit_sel];
         op_skip_io_bit_clear: sk = !p.io_bit;
         op_skip_io_bit_set: sk = p.io_bit;
         op_nop: sk = 1'b0;
         default:
            if (br_cond(p))
            begin
               r.taken = 1'b1;
               r.cycles = 2'h2;
               r.pc_next = p.pc + {{9{p.offset[6]}}, p.offset} + 16'h0001;
            end
      endcase
      if (sk)
      begin
         r.taken = 1'b1;
         r.cycles = p.next_two_word ? 2'h3 : 2'h2;
         r.pc_next = p.pc + 16'(r.cycles);
      end
      return r;
   endfunction

   function automatic bsfx_req_s rnd(bsfx_op_e op);
      bsfx_req_s p;
      p = $bits(p)'({$urandom, $urandom, $urandom});
      p.op = op;
      if (p.imm[0])
         p.rr = p.rd;
      return p;
   endfunction

   // ********************************************************************
   // Drivers, monitors and closing
   // ********************************************************************
   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr(logic [3:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(logic [3:0] a, logic [7:0] x);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      rq.push_back(x);
      @(posedge clock);
   endtask

   task automatic idle;
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask

   task automatic issue(bsfx_req_s p);
      int w;
      bsfx_res_s m;
      req <= p;
      req_valid <= 1'b1;
      reg_wr <= 1'b0;
      w = 0;
      do
      begin
         @(posedge clock);
         w++;
      end
      while (req_ready !== 1'b1 && w < 20);
      check("acc", req_ready, 1'b1);
      m = model(p);
      eq.push_back(m);
      n_taken += m.taken;
   endtask

   task automatic drain;
      int w;
      w = 0;
      while (eq.size() > 0 && w < 50)
      begin
         @(posedge clock);
         w++;
      end
      @(posedge clock);
      check("drain", 16'(eq.size()), 16'h0000);
   endtask

   always @(posedge clock)
   begin
      if (rd_d && !srst)
         check("rdata", reg_rdata, rq.pop_front());
      rd_d <= reg_rd;
   end

   always @(posedge clock)
      if (!srst && res_valid === 1'b1)
      begin
         if (eq.size() == 0)
            check("extra", 1'b1, 1'b0);
         else
         begin
            e = eq.pop_front();
            check("pc", res.pc_next, e.pc_next);
            check("cyc", res.cycles, e.cycles);
            check("tkn", res.taken, e.taken);
            check("fwr", res.flag_wr, e.flag_wr);
            check("st", res.status, e.status);
            check("push", res.push, e.push);
            check("pwr", res.prod_wr, e.prod_wr);
            if (e.prod_wr)
               check("prod", res.product, e.product);
            if (e.push)
               check("ret", res.ret_addr, e.ret_addr);
            last = e;
         end
      end

   initial
   begin
      repeat (5000) @(posedge clock);
      err_count++;
      conclude;
   end

   initial
   begin
      void'($urandom(70));
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      rd(ADDR_CTRL, CTRL_RESET);
      rd(ADDR_STAT, 8'h00);
      rd(ADDR_TAKEN, 8'h00);
      rd(4'hF, 8'h00);
      wr(4'hF, 8'hFF);
      wr(ADDR_CTRL, 8'h5A);
      rd(ADDR_CTRL, 8'h5A);
      idle;
      $display("test registers done");
      q = rnd(op_indirect_jump);
      req <= q;
      req_valid <= 1'b1;
      repeat (3) @(posedge clock);
      check("ready", req_ready, 1'b0);
      wr(ADDR_CTRL, CTRL_RESET);
      issue(q);
      req_valid <= 1'b0;
      drain;
      $display("test refusal done");
      wr(ADDR_TAKEN, 8'h00);
      idle;
      n_taken = 0;
      for (int i = op_nop; i <= op_branch_int_disabled; i++)
         repeat (6) issue(rnd(bsfx_op_e'(i)));
      req_valid <= 1'b0;
      drain;
      rd(ADDR_TAKEN, 8'(n_taken));
      rd(ADDR_PC_LO, last.pc_next[7:0]);
      rd(ADDR_PC_HI, last.pc_next[15:8]);
      rd(ADDR_STAT, {4'h0, last.cycles, last.taken, 1'b0});
      idle;
      idle;
      $display("test sweep done");
      conclude;
   end
endmodule
